// file: design/csp_map.svh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------
`define CSP_REG_AUX_EN 12'h000
`define CSP_REG_MEM_EN 12'h004
`define CSP_REG_PCI_EN 12'h008
`define CSP_REG_STATUS 12'h00c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSP_AUX_USB_BIT 1
`define CSP_AUX_SIO_BIT 2
`define CSP_STS_SIO_BIT 5
`define CSP_STS_DONE_BIT 8
`define CSP_STS_DOWN_BIT 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSP_AUX_RST 32'h0000_0006
`define CSP_MEM_RST 9'h1ff
`define CSP_PCI_RST 7'h7f

// ----------------------------------------------------------------
// Strap codes whose host clock is 100 MHz
// ----------------------------------------------------------------
`define CSP_FS_HOST100_A 5'h0d
`define CSP_FS_HOST100_B 5'h1d

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSP_MCLK_MHZ 100
`define CSP_STRAP_TIME_US 2000
`define CSP_STRAP_CYCLES (`CSP_STRAP_TIME_US * `CSP_MCLK_MHZ)

`endif

// file: design/csp_pkg.sv
// Types shared by the clock control block
package csp_pkg;

  // ----------------------------------------------------------------
  // Operating phase of the block
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSP_ST_STRAP = 2'b00, // Strap pins are inputs
    CSP_ST_RUN = 2'b01,   // Clocks delivered
    CSP_ST_DOWN = 2'b10   // Power-down, every clock output low
  } csp_state_e;

endpackage : csp_pkg

// file: design/csp_sync.sv
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module csp_sync (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_sync
);

  // First stage, read only by the second stage
  logic meta_q;

  // ----------------------------------------------------------------
  // Two stages; resets high so the block starts out of power-down
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : csp_sync

// file: design/csp_div2.sv
// Divide-by-two of a sampled clock source, used for the 24 MHz super I/O rate
`timescale 1ns/100ps
module csp_div2 (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_src,
  output logic o_half
);

  // Previous source level for rising edge detection
  logic prev_q;

  // ----------------------------------------------------------------
  // Toggle on each rising edge of the source
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_q <= 1'b0;
      o_half <= 1'b0;
    end else begin
      prev_q <= i_src;
      if (i_src && !prev_q) begin
        o_half <= ~o_half;
      end
    end
  end

endmodule : csp_div2

// file: design/csp_top.sv
// Strap capture, clock gating and power-down control of the clock generator
// Behaviour
// - Strap pins are inputs during power-up
// - Strap pins become outputs after 2 ms
// - Five strap levels select PLL frequency
// - Super I/O strap high 24 MHz, low 48
// - Low-power mode stops PLLs, outputs driven low
// - Two low samples enter power-down, gate at fall
// - Power-down input synchronised before use
// - Each PCI clock separately disableable by register
// - At 100 MHz host, memory clock inverted
// - Interrupt controller clock synchronous with PCI
// - 48 MHz outputs fixed, never spread
// - Reference clock delivered after strap phase
// - PCI outputs follow the 33 MHz source
// - Disabled outputs actively driven low
`timescale 1ns/100ps
`include "csp_map.svh"
module csp_top #(
  parameter int P_STRAP_CYCLES = `CSP_STRAP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Power-down pin, asynchronous
  input wire logic i_power_down_n_input,
  // PLL sources, sampled as synchronous levels
  input wire logic i_host_src,
  input wire logic i_mem_src,
  input wire logic i_mid_src,
  input wire logic i_pci_src,
  input wire logic i_usb_src,
  input wire logic i_ref_src,
  // PLL control
  output logic o_pll_enable,
  output logic o_spread_enable,
  output logic [4:0] o_frequency_select_straps,
  // Dual-purpose pins: 0..2 pci/fs0..2, 3 ref/fs3, 4 usb1/fs4, 5 super I/O
  input wire logic [5:0] i_strap_pin_in,
  output logic [5:0] o_strap_pin_out,
  output logic [5:0] o_strap_pin_oe,
  // Plain clock outputs
  output logic [1:0] o_host_clock_outputs,
  output logic [8:0] o_memory_clock_outputs,
  output logic [2:0] o_mid_rate_clock_outputs,
  output logic [3:0] o_pci_clock_upper,
  output logic o_interrupt_ctrl_clock_out,
  output logic o_fixed_usb_rate_clock
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = $clog2(P_STRAP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(P_STRAP_CYCLES - 1);

  csp_pkg::csp_state_e state_q, state_d; // Operating phase
  logic [CW-1:0] cnt_q;                   // Strap phase timer
  logic [4:0] fs_q;                       // Captured frequency straps
  logic sio_strap_q;                      // Captured super I/O strap
  logic pd_sync;                          // Synchronised power-down level
  logic pd_prev_q;                        // Previous synchronised sample
  logic pd_req_q;                         // Power-down requested
  logic [31:0] aux_q;                     // 48 MHz and super I/O enables
  logic [8:0] mem_en_q;                   // Memory clock enables
  logic [6:0] pci_en_q;                   // PCI clock enables
  logic [31:0] rdata_q;
  logic slverr_q;
  logic half_usb;                         // 24 MHz from the 48 MHz source
  logic run;                              // Outputs may toggle
  logic host_100;                         // Host runs at 100 MHz
  logic mem_src_eff;                      // Memory source after phase choice
  logic sio_src;                          // Selected super I/O source
  logic setup_ph;
  logic wr_acc;
  logic sel_aux, sel_mem, sel_pci, sel_sts, mapped;
  logic [31:0] status_w;
  logic [31:0] rdata_d;
  // Gate enables, updated only while their source is low
  logic [1:0] host_en_q, host_want;
  logic [8:0] mem_g_q, mem_want;
  logic [2:0] mid_en_q, mid_want;
  logic [7:0] pci_g_q, pci_want;          // Bit 7 is the interrupt controller clock
  logic [2:0] usb_g_q, usb_want;          // 0: fixed pin, 1: fs4 pin, 2: super I/O
  logic ref_g_q, ref_want;

  // ----------------------------------------------------------------
  // Power-down synchroniser
  // ----------------------------------------------------------------
  csp_sync u_pd_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async(i_power_down_n_input),
    .o_sync(pd_sync)
  );

  // 24 MHz source for the super I/O pin
  csp_div2 u_sio_div (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_src(i_usb_src),
    .o_half(half_usb)
  );

  // ----------------------------------------------------------------
  // Operating phase
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      csp_pkg::CSP_ST_STRAP: begin
        if (cnt_q == CNT_LAST) begin
          state_d = csp_pkg::CSP_ST_RUN;
        end
      end
      csp_pkg::CSP_ST_RUN: begin
        if (pd_req_q) begin
          state_d = csp_pkg::CSP_ST_DOWN;
        end
      end
      csp_pkg::CSP_ST_DOWN: begin
        if (!pd_req_q) begin
          state_d = csp_pkg::CSP_ST_RUN;
        end
      end
      default: begin
        state_d = csp_pkg::CSP_ST_STRAP;
      end
    endcase
  end

  // Phase register and strap timer
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= csp_pkg::CSP_ST_STRAP;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == csp_pkg::CSP_ST_STRAP) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  // Straps caught on the last input cycle, then frozen until reset
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fs_q <= 5'h00;
      sio_strap_q <= 1'b0;
    end else if (state_q == csp_pkg::CSP_ST_STRAP && cnt_q == CNT_LAST) begin
      fs_q <= i_strap_pin_in[4:0];
      sio_strap_q <= i_strap_pin_in[5];
    end
  end

  // ----------------------------------------------------------------
  // Power-down request: two consecutive low samples
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pd_prev_q <= 1'b1;
      pd_req_q <= 1'b0;
    end else begin
      pd_prev_q <= pd_sync;
      pd_req_q <= !pd_sync && !pd_prev_q;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and gate requests
  // ----------------------------------------------------------------
  assign run = (state_q == csp_pkg::CSP_ST_RUN);
  assign host_100 = (fs_q == `CSP_FS_HOST100_A) || (fs_q == `CSP_FS_HOST100_B);
  assign mem_src_eff = host_100 ? !i_mem_src : i_mem_src;
  assign sio_src = sio_strap_q ? half_usb : i_usb_src;
  // Disabled and powered-down outputs are requested low, never released
  assign host_want = {2{run}};
  assign mem_want = {9{run}} & mem_en_q;
  assign mid_want = {3{run}};
  assign pci_want = {run, {7{run}} & pci_en_q};
  assign usb_want = {run & aux_q[`CSP_AUX_SIO_BIT], {2{run & aux_q[`CSP_AUX_USB_BIT]}}};
  assign ref_want = run;

  // ----------------------------------------------------------------
  // Glitch-free gates: an enable changes only while its source is low,
  // so a stopped clock ends at its next high-to-low transition
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      host_en_q <= '0;
      mem_g_q <= '0;
      mid_en_q <= '0;
      pci_g_q <= '0;
      usb_g_q <= '0;
      ref_g_q <= 1'b0;
    end else begin
      if (!i_host_src) host_en_q <= host_want;
      if (!mem_src_eff) mem_g_q <= mem_want;
      if (!i_mid_src) mid_en_q <= mid_want;
      if (!i_pci_src) pci_g_q <= pci_want;
      if (!i_usb_src) usb_g_q[1:0] <= usb_want[1:0];
      if (!sio_src) usb_g_q[2] <= usb_want[2];
      if (!i_ref_src) ref_g_q <= ref_want;
    end
  end

  // ----------------------------------------------------------------
  // Output flip-flops; a low enable drives the pin low, never open
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_host_clock_outputs <= '0;
      o_memory_clock_outputs <= '0;
      o_mid_rate_clock_outputs <= '0;
      o_pci_clock_upper <= '0;
      o_interrupt_ctrl_clock_out <= 1'b0;
      o_fixed_usb_rate_clock <= 1'b0;
      o_strap_pin_out <= '0;
    end else begin
      o_host_clock_outputs <= {2{i_host_src}} & host_en_q;
      o_memory_clock_outputs <= {9{mem_src_eff}} & mem_g_q;
      o_mid_rate_clock_outputs <= {3{i_mid_src}} & mid_en_q;
      o_pci_clock_upper <= {4{i_pci_src}} & pci_g_q[6:3];
      o_interrupt_ctrl_clock_out <= i_pci_src & pci_g_q[7];
      o_fixed_usb_rate_clock <= i_usb_src & usb_g_q[0];
      o_strap_pin_out <= {sio_src & usb_g_q[2], i_usb_src & usb_g_q[1],
                          i_ref_src & ref_g_q, {3{i_pci_src}} & pci_g_q[2:0]};
    end
  end

  // Pins turn to outputs once the strap phase is over, and stay so
  assign o_strap_pin_oe = {6{state_q != csp_pkg::CSP_ST_STRAP}};
  assign o_frequency_select_straps = fs_q;
  assign o_pll_enable = run;
  // Spread applies to the PLL groups only; 48 MHz sources bypass it
  assign o_spread_enable = run;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup_ph = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign sel_aux = (i_paddr == `CSP_REG_AUX_EN);
  assign sel_mem = (i_paddr == `CSP_REG_MEM_EN);
  assign sel_pci = (i_paddr == `CSP_REG_PCI_EN);
  assign sel_sts = (i_paddr == `CSP_REG_STATUS);
  assign mapped = sel_aux || sel_mem || sel_pci || sel_sts;
  assign status_w = {22'h0, pd_req_q, state_q != csp_pkg::CSP_ST_STRAP,
                     2'h0, sio_strap_q, fs_q};
  assign rdata_d = sel_aux ? aux_q :
                   sel_mem ? {23'h0, mem_en_q} :
                   sel_pci ? {25'h0, pci_en_q} :
                   sel_sts ? status_w : 32'h0;
  // Zero wait states: the answer is ready in the access phase
  assign o_pready = i_psel && i_penable;
  assign o_prdata = rdata_q;
  assign o_pslverr = slverr_q;

  // Read data and error caught in the setup cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup_ph) begin
      rdata_q <= i_pwrite ? 32'h0 : rdata_d;
      slverr_q <= !mapped;
    end
  end

  // Enable registers; status writes are ignored
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aux_q <= `CSP_AUX_RST;
      mem_en_q <= `CSP_MEM_RST;
      pci_en_q <= `CSP_PCI_RST;
    end else if (wr_acc) begin
      if (sel_aux) aux_q <= i_pwdata & `CSP_AUX_RST;
      if (sel_mem) mem_en_q <= i_pwdata[8:0];
      if (sel_pci) pci_en_q <= i_pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  AST_STRAP_INPUT: assert property (
    (state_q == csp_pkg::CSP_ST_STRAP) |-> (o_strap_pin_oe == 6'h00))
    else $error("strap pin driven during strap phase");
  AST_STRAP_RELEASE: assert property (
    (state_q == csp_pkg::CSP_ST_STRAP && cnt_q == CNT_LAST) |=> (o_strap_pin_oe == 6'h3f))
    else $error("strap pins not turned to outputs at end of strap time");
  AST_FS_HELD: assert property (
    (state_q != csp_pkg::CSP_ST_STRAP) |=> $stable(o_frequency_select_straps))
    else $error("frequency select changed after capture");
  AST_SIO_48: assert property (
    (!sio_strap_q && usb_g_q[2] && run) |=> (o_strap_pin_out[5] == $past(i_usb_src)))
    else $error("super I/O clock not at 48 MHz rate");
  AST_PD_PLL_OFF: assert property (
    pd_req_q |=> !o_pll_enable)
    else $error("PLL still enabled in power-down");
  AST_PD_TWO_LOW: assert property (
    (!pd_sync && !pd_prev_q) |=> pd_req_q)
    else $error("power-down not entered after two low samples");
  AST_PD_LATENCY: assert property (
    $rose(pd_req_q) |-> !$past(i_power_down_n_input, 3))
    else $error("power-down acted on an unsynchronised input");
  AST_PCI_OFF: assert property (
    (!pci_g_q[0]) |=> !o_strap_pin_out[0])
    else $error("disabled PCI clock not held low");
  AST_HOST_GATE: assert property (
    (!run && !i_host_src) |=> ##1 (o_host_clock_outputs == 2'b00))
    else $error("host clock not held low after its falling edge");
  AST_INTERRUPT_CTRL_CLOCK_OUT_SYNC: assert property (
    (pci_g_q[7] && pci_g_q[3]) |=> (o_interrupt_ctrl_clock_out == o_pci_clock_upper[0]))
    else $error("interrupt controller clock not in step with PCI clock");

  COV_RUN: cover property ($rose(run));
  COV_PD_ENTER: cover property ($rose(pd_req_q) ##[1:20] !pd_req_q);
  COV_PCI_WRITE: cover property (wr_acc && sel_pci);

endmodule : csp_top

// file: bench/csp_load_model.sv
// Far-side model: PLL source clocks and the strapped dual-purpose pins
`timescale 1ns/100ps
module csp_load_model (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [5:0] i_straps,
  input wire logic [5:0] i_pin_drv,
  input wire logic [5:0] i_pin_oe,
  output logic [5:0] o_pin_lvl,
  output logic [5:0] o_src
);
  // ------------------------------------------------------------
  // Source clocks
  // ------------------------------------------------------------
  logic [3:0] div_q; // Shared divider for every source
  // Sources restart with reset so expected edge counts stay exact
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  // Order: ref, usb, pci, mid, mem, host; host, mem and usb share one rate
  assign o_src = {div_q[3], div_q[1], div_q[2], div_q[2], div_q[1], div_q[1]};
  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  // Driver wins when enabled, otherwise the strap resistor sets the level
  assign o_pin_lvl = (i_pin_oe & i_pin_drv) | (~i_pin_oe & i_straps);
endmodule : csp_load_model

// file: bench/csp_top_tb.sv
// Self-checking testbench of the clock control block
`timescale 1ns/100ps
`include "csp_map.svh"
module csp_top_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic i_mclk, i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic i_power_down_n_input, o_pll_enable, o_spread_enable, er;
  logic [4:0] o_frequency_select_straps;
  logic [5:0] i_strap_pin_in, o_strap_pin_out, o_strap_pin_oe, straps, src;
  logic [1:0] o_host_clock_outputs;
  logic [8:0] o_memory_clock_outputs;
  logic [2:0] o_mid_rate_clock_outputs;
  logic [3:0] o_pci_clock_upper;
  logic o_interrupt_ctrl_clock_out, o_fixed_usb_rate_clock;
  wire i_host_src = src[0], i_mem_src = src[1], i_mid_src = src[2];
  wire i_pci_src = src[3], i_usb_src = src[4], i_ref_src = src[5];
  int n_fail, samples_checked;
  // Every clock output in one vector, for the all-low checks
  wire [25:0] all_clk = {o_host_clock_outputs, o_memory_clock_outputs, o_mid_rate_clock_outputs,
    o_pci_clock_upper, o_interrupt_ctrl_clock_out, o_fixed_usb_rate_clock, o_strap_pin_out};

  // Short strap phase keeps the run brief
  csp_top #(.P_STRAP_CYCLES(20)) csp_top_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_power_down_n_input(i_power_down_n_input), .i_host_src(i_host_src),
    .i_mem_src(i_mem_src), .i_mid_src(i_mid_src), .i_pci_src(i_pci_src),
    .i_usb_src(i_usb_src), .i_ref_src(i_ref_src), .o_pll_enable(o_pll_enable),
    .o_spread_enable(o_spread_enable),
    .o_frequency_select_straps(o_frequency_select_straps),
    .i_strap_pin_in(i_strap_pin_in), .o_strap_pin_out(o_strap_pin_out),
    .o_strap_pin_oe(o_strap_pin_oe), .o_host_clock_outputs(o_host_clock_outputs),
    .o_memory_clock_outputs(o_memory_clock_outputs),
    .o_mid_rate_clock_outputs(o_mid_rate_clock_outputs),
    .o_pci_clock_upper(o_pci_clock_upper),
    .o_interrupt_ctrl_clock_out(o_interrupt_ctrl_clock_out),
    .o_fixed_usb_rate_clock(o_fixed_usb_rate_clock));
  csp_load_model csp_load_model_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_straps(straps),
    .i_pin_drv(o_strap_pin_out), .i_pin_oe(o_strap_pin_oe), .o_pin_lvl(i_strap_pin_in),
    .o_src(src));

  // Free-running 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    chk("pready", 1, {31'h0, o_pready});
    // A slave that never answers ends the run here
    if (o_pready !== 1'b1) report_and_stop;
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // Reset held 16 cycles with the given strap levels
  task automatic do_reset(input logic [5:0] s);
    @(posedge i_mclk);
    straps <= s;
    i_arst_n <= 1'b0;
    repeat (16) @(posedge i_mclk);
    i_arst_n <= 1'b1;
  endtask : do_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Strap capture, pin turnaround, then rates and phase of the groups
  task automatic sc_boot(input logic [5:0] s);
    logic [4:0] v, pv;
    int c[5];
    logic fs100;
    fs100 = (s[4:0] == `CSP_FS_HOST100_A) || (s[4:0] == `CSP_FS_HOST100_B);
    do_reset(s);
    repeat (19) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("oe in strap phase", 0, {26'h0, o_strap_pin_oe});
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("oe after strap phase", 32'h3f, {26'h0, o_strap_pin_oe});
    chk("spread on", 1, {31'h0, o_spread_enable});
    chk("fs straps", {27'h0, s[4:0]}, {27'h0, o_frequency_select_straps});
    apb(1'b0, `CSP_REG_STATUS, 32'h0);
    chk("status", {24'h1, 2'b00, s}, {22'h0, rd[9:0]});
    @(posedge i_mclk);
    straps <= ~s;
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("held straps", {27'h0, s[4:0]}, {27'h0, o_frequency_select_straps});
    pv = {o_mid_rate_clock_outputs[0], o_strap_pin_out[3], o_strap_pin_out[0],
          o_strap_pin_out[5], o_fixed_usb_rate_clock};
    c = '{0, 0, 0, 0, 0};
    repeat (64) begin
      @(negedge i_mclk);
      v = {o_mid_rate_clock_outputs[0], o_strap_pin_out[3], o_strap_pin_out[0],
           o_strap_pin_out[5], o_fixed_usb_rate_clock};
      for (int j = 0; j < 5; j++) begin
        if (v[j] && !pv[j]) c[j]++;
      end
      pv = v;
      chk("mem phase", {31'h0, o_host_clock_outputs[0] ^ fs100}, {31'h0, o_memory_clock_outputs[0]});
      chk("interrupt_ctrl_clock_out", {31'h0, o_strap_pin_out[0]}, {31'h0, o_interrupt_ctrl_clock_out});
    end
    chk("usb rises", 16, c[0]);
    chk("sio rises", s[5] ? 8 : 16, c[1]);
    chk("pci rises", 8, c[2]);
    chk("ref rises", 4, c[3]);
    chk("mid rises", 8, c[4]);
  endtask : sc_boot

  // Reset values, unmapped access, read-only status, auxiliary disable
  task automatic sc_regs;
    apb(1'b0, `CSP_REG_AUX_EN, 32'h0);
    chk("aux reset", `CSP_AUX_RST, rd);
    apb(1'b0, `CSP_REG_MEM_EN, 32'h0);
    chk("mem reset", {23'h0, `CSP_MEM_RST}, rd);
    apb(1'b0, `CSP_REG_PCI_EN, 32'h0);
    chk("pci reset", {25'h0, `CSP_PCI_RST}, rd);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk("unmapped err", 1, {31'h0, er});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped data", 32'h1, {rd[31:1], er});
    apb(1'b1, `CSP_REG_STATUS, 32'h0);
    apb(1'b0, `CSP_REG_STATUS, 32'h0);
    chk("status kept", 32'h1, {31'h0, rd[8]});
    apb(1'b1, `CSP_REG_AUX_EN, 32'h0);
    apb(1'b1, `CSP_REG_MEM_EN, 32'h0);
    repeat (8) @(posedge i_mclk);
    repeat (16) begin
      @(negedge i_mclk);
      chk("aux off", 0, {29'h0, o_strap_pin_out[5:4], o_fixed_usb_rate_clock});
      chk("mem off", 0, {23'h0, o_memory_clock_outputs});
    end
    apb(1'b1, `CSP_REG_AUX_EN, `CSP_AUX_RST);
    apb(1'b1, `CSP_REG_MEM_EN, {23'h0, `CSP_MEM_RST});
  endtask : sc_regs

  // Each PCI clock gated on its own bit
  task automatic sc_pci;
    logic [6:0] hi;
    apb(1'b1, `CSP_REG_PCI_EN, 32'h2a);
    repeat (8) @(posedge i_mclk);
    hi = 7'h0;
    repeat (32) begin
      @(negedge i_mclk);
      hi = hi | {o_pci_clock_upper, o_strap_pin_out[2:0]};
    end
    chk("pci active set", 32'h2a, {25'h0, hi});
    chk("oe kept", 32'h3f, {26'h0, o_strap_pin_oe});
    apb(1'b1, `CSP_REG_PCI_EN, {25'h0, `CSP_PCI_RST});
  endtask : sc_pci

  // Power-down: glitch ignored, sync latency, all clock outputs low, exit
  task automatic sc_pdown;
    @(posedge i_mclk);
    i_power_down_n_input <= 1'b0;
    @(posedge i_mclk);
    i_power_down_n_input <= 1'b1;
    repeat (10) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("glitch ignored", 1, {31'h0, o_pll_enable});
    @(posedge i_mclk);
    i_power_down_n_input <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("pll before sync", 1, {31'h0, o_pll_enable});
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("pll off", 0, {31'h0, o_pll_enable});
    chk("spread off", 0, {31'h0, o_spread_enable});
    repeat (8) @(posedge i_mclk);
    repeat (16) begin
      @(negedge i_mclk);
      chk("outputs low", 0, {6'h0, all_clk});
    end
    apb(1'b0, `CSP_REG_STATUS, 32'h0);
    chk("down flag", 1, {31'h0, rd[9]});
    i_power_down_n_input <= 1'b1;
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("pll back", 1, {31'h0, o_pll_enable});
  endtask : sc_pdown

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    samples_checked = 0;
    i_arst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_power_down_n_input = 1'b1;
    straps = 6'h2d;
    sc_boot(6'h2d);
    sc_regs;
    sc_pci;
    sc_pdown;
    sc_boot(6'h02);
    report_and_stop;
  end

  // A hang counts as a mismatch
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
endmodule : csp_top_tb
